// *** iq_converter_data_port.sv ***
// Data port of the board's output and input converters.
//
// Functional notes
// - Each output converter takes a full 16-bit word, bit 0 least significant.
// - Code 0 gives minimum true output, 65535 maximum; midpoint between 32767/32768.
// - Output word is captured on the rising word clock edge; controller holds it.
// - Two independent output converters, in-phase and quadrature, each own bus and clock.
// - Input converters deliver 14-bit samples at the encode clock rate.
// - A sample appears at the outputs four encode cycles after its sampling edge.
// - Data-ready strobe is active high, an inverted and delayed encode clock.
// - Four input channels: beam, reflected, forward, cavity, each with word, flag, strobe.
// - Sample words are two's complement; overrange clips the word to full scale.
`timescale 1ns/1ps
`default_nettype none

module iq_converter_data_port
	import iq_converter_pkg::*;
#(
	parameter int DACS = NUM_DAC,
	parameter int ADCS = NUM_ADC
) (
	// System clock and reset
	input  wire logic                                     clock_i,
	input  wire logic                                     rst_n_i,
	// Output converters, controller side
	input  wire logic [DACS-1:0]                          dac_word_clock_i,
	input  wire logic [DACS-1:0][DAC_WIDTH-1:0]           dac_word_i,
	// Output converter levels
	output logic      [DACS-1:0][DAC_WIDTH-1:0]           dac_true_current_o,
	output logic      [DACS-1:0][DAC_WIDTH-1:0]           dac_complement_current_o,
	// Input converters, analog side on the encode clock
	input  wire logic                                     sample_clock_i,
	input  wire logic [ADCS-1:0][ANALOG_WIDTH-1:0]        analog_in_pos_i,
	// Input converter sample streams
	output logic      [ADCS-1:0][ADC_WIDTH-1:0]           adc_word_o,
	output logic      [ADCS-1:0]                          adc_overrange_o,
	output logic      [ADCS-1:0]                          sample_valid_strobe_o
);

	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	if (DACS != NUM_DAC) begin : g_bad_dacs
		$error("The board carries exactly one in-phase and one quadrature converter.");
	end
	if (ADCS != NUM_ADC) begin : g_bad_adcs
		$error("The board carries exactly four input channels.");
	end

	// ----------------------------------------------------------------
	// Encode-domain sampling, one pipeline per input channel
	// ----------------------------------------------------------------
	logic [ADCS-1:0][ADC_WIDTH-1:0] enc_word;
	logic [ADCS-1:0]                enc_overrange;

	for (genvar ch = 0; ch < ADCS; ch++) begin : g_adc
		adc_channel_pipe #(
			.WIDTH    (ADC_WIDTH),
			.IN_WIDTH (ANALOG_WIDTH),
			.LATENCY  (ADC_LATENCY_CYCLES)
		) u_pipe (
			.sample_clock_i (sample_clock_i),
			.rst_n_i        (rst_n_i),
			.analog_in_i    (analog_in_pos_i[ch]),
			.word_o         (enc_word[ch]),
			.overrange_o    (enc_overrange[ch])
		);
	end

	// ----------------------------------------------------------------
	// System-domain state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [DACS-1:0]                wclk_meta;
		logic [DACS-1:0]                wclk_sync;
		logic [DACS-1:0]                wclk_prev;
		logic [DACS-1:0][DAC_WIDTH-1:0] word_meta;
		logic [DACS-1:0][DAC_WIDTH-1:0] word_sync;
		logic [DACS-1:0][DAC_WIDTH-1:0] dac_true;
		logic [DACS-1:0][DAC_WIDTH-1:0] dac_comp;
		logic                           enc_meta;
		logic                           enc_sync;
		logic                           enc_prev;
		logic [ADCS-1:0][ADC_WIDTH-1:0] adc_word;
		logic [ADCS-1:0]                adc_ovr;
		logic [ADCS-1:0]                strobe;
	} port_state_t;

	port_state_t state;
	port_state_t next_state;

	// The encode-domain word is held for a whole encode period, so it is
	// taken across on the synchronised falling encode edge, half a period
	// after it last changed; no bit can be in motion at that point.
	always_comb begin
		next_state = state;
		// Output converters: synchronise clock and word together.
		next_state.wclk_meta = dac_word_clock_i;
		next_state.wclk_sync = state.wclk_meta;
		next_state.wclk_prev = state.wclk_sync;
		next_state.word_meta = dac_word_i;
		next_state.word_sync = state.word_meta;
		for (int d = 0; d < DACS; d++) begin
			if (state.wclk_sync[d] && !state.wclk_prev[d]) begin
				next_state.dac_true[d] = state.word_sync[d];
				next_state.dac_comp[d] = ~state.word_sync[d];
			end
		end
		// Input converters: follow the encode clock, inverted and delayed.
		next_state.enc_meta = sample_clock_i;
		next_state.enc_sync = state.enc_meta;
		next_state.enc_prev = state.enc_sync;
		if (state.enc_prev && !state.enc_sync) begin
			next_state.adc_word = enc_word;
			next_state.adc_ovr  = enc_overrange;
		end
		// Strobe rises one cycle after the word has been updated, giving setup.
		next_state.strobe = {ADCS{~state.enc_prev}};
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state.wclk_meta <= '0;
			state.wclk_sync <= '0;
			state.wclk_prev <= '0;
			state.word_meta <= '0;
			state.word_sync <= '0;
			state.dac_true  <= {DACS{DAC_RESET_CODE}};
			state.dac_comp  <= {DACS{~DAC_RESET_CODE}};
			state.enc_meta  <= 1'b0;
			state.enc_sync  <= 1'b0;
			state.enc_prev  <= 1'b0;
			state.adc_word  <= {ADCS{ADC_RESET_WORD}};
			state.adc_ovr   <= '0;
			state.strobe    <= '0;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, straight from registers
	// ----------------------------------------------------------------
	assign dac_true_current_o       = state.dac_true;
	assign dac_complement_current_o = state.dac_comp;
	assign adc_word_o               = state.adc_word;
	assign adc_overrange_o          = state.adc_ovr;
	assign sample_valid_strobe_o    = state.strobe;

endmodule // iq_converter_data_port

`default_nettype wire

// *** iq_converter_pkg.sv ***
// Shared constants for the converter data port of the I/Q board.
package iq_converter_pkg;

	// ----------------------------------------------------------------
	// Converter widths and counts
	// ----------------------------------------------------------------
	localparam int DAC_WIDTH    = 16;
	localparam int NUM_DAC      = 2;
	localparam int ADC_WIDTH    = 14;
	localparam int NUM_ADC      = 4;
	localparam int ANALOG_WIDTH = 16;

	// ----------------------------------------------------------------
	// Channel positions in the output converter and sample buses
	// ----------------------------------------------------------------
	localparam int DAC_IN_PHASE   = 0;
	localparam int DAC_QUADRATURE = 1;
	localparam int ADC_BEAM       = 0;
	localparam int ADC_REFLECTED  = 1;
	localparam int ADC_FORWARD    = 2;
	localparam int ADC_CAVITY     = 3;

	// ----------------------------------------------------------------
	// Timing counts
	// ----------------------------------------------------------------
	// Encode cycles from the sampling edge to the word at the outputs.
	localparam int ADC_LATENCY_CYCLES = 4;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	// Midscale code, so both current outputs sit near the centre.
	localparam logic [15:0] DAC_RESET_CODE = 16'h8000;
	localparam logic [13:0] ADC_RESET_WORD = 14'h0000;

endpackage : iq_converter_pkg

// *** adc_channel_pipe.sv ***
// Encode-domain sampling pipeline of one input converter channel.
`timescale 1ns/1ps
`default_nettype none

module adc_channel_pipe
	import iq_converter_pkg::*;
#(
	parameter int WIDTH    = ADC_WIDTH,
	parameter int IN_WIDTH = ANALOG_WIDTH,
	parameter int LATENCY  = ADC_LATENCY_CYCLES
) (
	// Encode clock and reset
	input  wire logic                        sample_clock_i,
	input  wire logic                        rst_n_i,
	// Analog input level, as a signed value
	input  wire logic signed [IN_WIDTH-1:0]  analog_in_i,
	// Sample word and overrange flag
	output logic             [WIDTH-1:0]     word_o,
	output logic                             overrange_o
);

	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	if (LATENCY < 3) begin : g_bad_latency
		$error("Latency must cover the two input flip-flops and saturation.");
	end
	if (IN_WIDTH <= WIDTH) begin : g_bad_width
		$error("Analog input must be wider than the sample word.");
	end

	localparam logic signed [IN_WIDTH-1:0] FULL_POS = IN_WIDTH'((1 << (WIDTH - 1)) - 1);
	localparam logic signed [IN_WIDTH-1:0] FULL_NEG = IN_WIDTH'(-(1 << (WIDTH - 1)));

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [LATENCY-1:0][IN_WIDTH-1:0] stage;
		logic [WIDTH-1:0]                 word;
		logic                             overrange;
	} pipe_state_t;

	pipe_state_t state;
	pipe_state_t next_state;

	// Stage 0 is the aperture capture; stage 1 only reads it, so the
	// first two stages double as the input synchroniser.
	always_comb begin
		logic signed [IN_WIDTH-1:0] level;
		level = '0;
		next_state = state;
		next_state.stage[0] = analog_in_i;
		for (int i = 1; i < LATENCY; i++) begin
			next_state.stage[i] = state.stage[i-1];
		end
		level = signed'(state.stage[LATENCY-1]);
		if (level > FULL_POS) begin
			next_state.word      = {1'b0, {(WIDTH-1){1'b1}}};
			next_state.overrange = 1'b1;
		end else if (level < FULL_NEG) begin
			next_state.word      = {1'b1, {(WIDTH-1){1'b0}}};
			next_state.overrange = 1'b1;
		end else begin
			next_state.word      = level[WIDTH-1:0];
			next_state.overrange = 1'b0;
		end
	end

	always_ff @(posedge sample_clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state.stage     <= '0;
			state.word      <= ADC_RESET_WORD;
			state.overrange <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign word_o      = state.word;
	assign overrange_o = state.overrange;

endmodule // adc_channel_pipe

`default_nettype wire

// *** iq_converter_data_port_assertions.sv ***
// Pin-level assertions for the converter data port.
`timescale 1ns/1ps
`default_nettype none
module iq_port_checker
	import iq_converter_pkg::*;
#(
	parameter int DACS = NUM_DAC,
	parameter int ADCS = NUM_ADC
) (
	// Clock and reset
	input wire logic                 clock_i,
	input wire logic                 rst_n_i,
	// Output converters
	input wire logic [DACS-1:0]      dac_word_clock_i,
	input wire logic [DACS-1:0][15:0] dac_word_i,
	input wire logic [DACS-1:0][15:0] dac_true_current_o,
	input wire logic [DACS-1:0][15:0] dac_complement_current_o,
	// Sample streams
	input wire logic [ADCS-1:0][13:0] adc_word_o,
	input wire logic [ADCS-1:0]      adc_overrange_o,
	input wire logic [ADCS-1:0]      sample_valid_strobe_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_rise(int k);
		!dac_word_clock_i[k] ##1 dac_word_clock_i[k];
	endsequence
	AST_DAC_I: assert property (s_rise(0) |-> ##3
		dac_true_current_o[0] == $past(dac_word_i[0], 3)) else $error("I word not taken");
	AST_DAC_Q: assert property (s_rise(1) |-> ##3
		dac_true_current_o[1] == $past(dac_word_i[1], 3)) else $error("Q word not taken");
	AST_DAC_HOLD: assert property ($changed(dac_true_current_o[0]) |->
		$past(dac_word_clock_i[0], 3) && !$past(dac_word_clock_i[0], 4)) else $error("I moved");
	AST_DAC_COMP: assert property (dac_complement_current_o == ~dac_true_current_o)
		else $error("complement wrong");
	AST_STB_SAME: assert property (sample_valid_strobe_o == '0 || &sample_valid_strobe_o)
		else $error("strobes differ");
	AST_STB_SETUP: assert property ($rose(sample_valid_strobe_o[0]) |=>
		$stable(adc_word_o) && $stable(adc_overrange_o)) else $error("word moved at strobe");
	AST_WORD_LOW: assert property ($changed(adc_word_o) |-> !sample_valid_strobe_o[0])
		else $error("word moved with strobe high");
	AST_OVR_SAT: assert property (adc_overrange_o[0] |->
		adc_word_o[0] inside {14'h1fff, 14'h2000}) else $error("overrange without clip");
endmodule // iq_port_checker
bind iq_converter_data_port iq_port_checker #(.DACS(DACS), .ADCS(ADCS)) u_iq_port_checker (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .dac_word_clock_i(dac_word_clock_i),
	.dac_word_i(dac_word_i), .dac_true_current_o(dac_true_current_o),
	.dac_complement_current_o(dac_complement_current_o), .adc_word_o(adc_word_o),
	.adc_overrange_o(adc_overrange_o), .sample_valid_strobe_o(sample_valid_strobe_o));
`default_nettype wire

// *** iq_controller_model.sv ***
// Controller model: drives both word buses and captures the sample streams.
`timescale 1ns/1ps
`default_nettype none
module iq_controller_model (
	// Clock and reset
	input  wire logic            clock_i,
	input  wire logic            rst_n_i,
	// Signed drive values
	input  wire logic [15:0]      drive_i_i,
	input  wire logic [15:0]      drive_q_i,
	// Output converter buses
	output logic      [1:0]       word_clock_o,
	output logic      [1:0][15:0] word_o,
	// Sample streams and captures
	input  wire logic [3:0][13:0] adc_word_i,
	input  wire logic [3:0]       adc_overrange_i,
	input  wire logic [3:0]       strobe_i,
	output logic      [3:0][13:0] cap_word_o,
	output logic      [3:0]       cap_overrange_o,
	// Offset-free I and Q of the beam channel
	output logic      [13:0]      iq_i_o,
	output logic      [13:0]      iq_q_o
);
	logic [3:0]        phase;
	logic [1:0]        quad;
	logic [3:0][13:0]  quad_word;
	logic signed [14:0] diff_i;
	logic signed [14:0] diff_q;
	// Halving the I minus -I difference cancels any DC offset of the input.
	assign diff_i = $signed({quad_word[0][13], quad_word[0]}) -
		$signed({quad_word[2][13], quad_word[2]});
	assign diff_q = $signed({quad_word[1][13], quad_word[1]}) -
		$signed({quad_word[3][13], quad_word[3]});
	assign iq_i_o = diff_i[14:1];
	assign iq_q_o = diff_q[14:1];
	// Words move on the falling word clock edge, half a period clear of the capture.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase <= 4'h0;
			word_clock_o <= 2'h0;
			word_o <= '0;
		end else begin
			phase <= (phase == 4'h9) ? 4'h0 : phase + 4'h1;
			if (phase == 4'h4) begin
				word_clock_o <= 2'h0;
				word_o[0] <= drive_i_i ^ 16'h8000;
				word_o[1] <= drive_q_i ^ 16'h8000;
			end
			if (phase == 4'h9) word_clock_o <= 2'h3;
		end
	end
	always_ff @(posedge strobe_i[0] or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cap_word_o <= '0;
			cap_overrange_o <= 4'h0;
			quad <= 2'h0;
			quad_word <= '0;
		end else begin
			cap_word_o <= adc_word_i;
			cap_overrange_o <= adc_overrange_i;
			quad <= quad + 2'h1;
			quad_word[quad] <= adc_word_i[0];
		end
	end
endmodule // iq_controller_model
`default_nettype wire

// *** iq_converter_data_port_tb_top.sv ***
// Self-checking bench for the converter data port.
`timescale 1ns/1ps
`default_nettype none
module iq_converter_data_port_tb_top;
	logic            clock_i = 1'b0;
	logic            rst_n_i = 1'b0;
	logic            sample_clock_i = 1'b0;
	logic [15:0]      drive_i = 16'h0;
	logic [15:0]      drive_q = 16'h0;
	logic [1:0]       wclk;
	logic [1:0][15:0] dword, dtrue, dcomp;
	logic [3:0][15:0] analog_in_pos = '0;
	logic [3:0][13:0] aword, cword;
	logic [3:0]       aovr, stb, covr;
	logic [13:0]      iq_i, iq_q;
	int              err_count = 0, n_compared = 0, cycles = 0, falls = 0;
	always #2.5 clock_i = ~clock_i;
	always #15 sample_clock_i = ~sample_clock_i;
	always @(negedge sample_clock_i) falls++;
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 2000) begin
			err_count++;
			close_out();
		end
	end
	iq_converter_data_port u_iq_converter_data_port (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.dac_word_clock_i(wclk), .dac_word_i(dword), .dac_true_current_o(dtrue),
		.dac_complement_current_o(dcomp), .sample_clock_i(sample_clock_i),
		.analog_in_pos_i(analog_in_pos), .adc_word_o(aword), .adc_overrange_o(aovr),
		.sample_valid_strobe_o(stb));
	iq_controller_model u_iq_controller_model (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.drive_i_i(drive_i), .drive_q_i(drive_q), .word_clock_o(wclk), .word_o(dword),
		.adc_word_i(aword), .adc_overrange_i(aovr), .strobe_i(stb), .cap_word_o(cword),
		.cap_overrange_o(covr), .iq_i_o(iq_i), .iq_q_o(iq_q));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic close_out();
		$display("compared %0d, mismatched %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic t_dac_codes();
		logic [15:0] codes [5] = '{16'h0000, 16'h7fff, 16'h8000, 16'hffff, 16'h5a3c};
		foreach (codes[k]) begin
			@(posedge clock_i);
			drive_i <= codes[k] ^ 16'h8000;
			drive_q <= ~codes[k] ^ 16'h8000;
			for (int n = 0; n < 40 && dtrue !== {~codes[k], codes[k]}; n++) @(posedge clock_i);
			#1;
			chk("I level", codes[k], dtrue[0]);
			chk("I complement", ~codes[k], dcomp[0]);
			chk("Q level", ~codes[k], dtrue[1]);
			chk("Q complement", codes[k], dcomp[1]);
		end
		$display("done: output codes");
	endtask
	task automatic t_adc_values();
		logic [15:0] vin [8] = '{16'h1fff, 16'he000, 16'h2000, 16'hdcd8,
			16'h7fff, 16'hfffb, 16'h0064, 16'hdfff};
		logic [13:0] vw [8] = '{14'h1fff, 14'h2000, 14'h1fff, 14'h2000,
			14'h1fff, 14'h3ffb, 14'h0064, 14'h2000};
		logic [7:0] vo = 8'b1001_1100;
		for (int r = 0; r < 8; r += 4) begin
			@(posedge clock_i);
			for (int c = 0; c < 4; c++) analog_in_pos[c] <= vin[r + c];
			// A fixed wait, since a repeated value would end a polling loop early.
			repeat (8) @(posedge sample_clock_i);
			@(posedge clock_i);
			#1;
			for (int c = 0; c < 4; c++) begin
				chk("captured word", {2'h0, vw[r + c]}, {2'h0, cword[c]});
				chk("overrange", {15'h0, vo[r + c]}, {15'h0, covr[c]});
			end
		end
		$display("done: sample values");
	endtask
	task automatic t_latency();
		int f0;
		@(posedge sample_clock_i);
		@(posedge clock_i);
		analog_in_pos[0] <= 16'h0123;
		@(posedge sample_clock_i);
		f0 = falls;
		for (int n = 0; n < 100 && aword[0] !== 14'h0123; n++) @(posedge clock_i);
		// The word crosses on the encode fall that follows its last pipeline edge.
		chk("encode falls to word", 16'(iq_converter_pkg::ADC_LATENCY_CYCLES + 1),
			16'(falls - f0));
		$display("done: sample latency");
	endtask
	task automatic t_dc_offset();
		repeat (12) @(posedge sample_clock_i);
		@(posedge clock_i);
		#1;
		chk("I estimate", 16'h0, {2'h0, iq_i});
		chk("Q estimate", 16'h0, {2'h0, iq_q});
		$display("done: offset removal");
	endtask
	initial begin
		repeat (5) @(posedge clock_i);
		repeat (2) @(posedge sample_clock_i);
		#1;
		chk("reset level", 16'h8000, dtrue[0]);
		chk("reset strobe", 16'h0, {12'h0, stb});
		@(posedge clock_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		t_dac_codes();
		t_adc_values();
		t_latency();
		t_dc_offset();
		close_out();
	end
endmodule // iq_converter_data_port_tb_top
`default_nettype wire
